// [verilog/sptm_pkg.sv]
// constants shared by the supervision timer design files
// assumes a single 25 MHz system clock and an APB register slave
package sptm_pkg;

    // ------------------------------------------------------------
    // clock and bus
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          APB_ADDR_W      = 12;
    localparam int          APB_DATA_W      = 32;
    localparam int          REG_W           = 8;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_ADDR       = 12'h060;
    localparam logic [11:0] CAUSE_ADDR      = 12'h064;

    // ------------------------------------------------------------
    // timer_control_register fields
    // ------------------------------------------------------------
    localparam int          IRQ_FLAG_BIT    = 7;
    localparam int          IRQ_EN_BIT      = 6;
    localparam int          PER3_BIT        = 5;
    localparam int          UNLOCK_BIT      = 4;
    localparam int          RST_EN_BIT      = 3;
    localparam int          PER_LO_MSB      = 2;
    localparam int          PER_LO_LSB      = 0;

    // ------------------------------------------------------------
    // reset_cause_register fields
    // ------------------------------------------------------------
    localparam int          CAUSE_TIMEOUT_BIT = 3;
    localparam int          CAUSE_SUPPLY_BIT  = 2;
    localparam int          CAUSE_PIN_BIT     = 1;
    localparam int          CAUSE_POWER_BIT   = 0;
    localparam logic [3:0]  CAUSE_UNUSED_RD   = 4'h0;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [3:0]  PERIOD_RST      = 4'h0;
    localparam logic [3:0]  PERIOD_MAX      = 4'h9;
    localparam logic [2:0]  UNLOCK_CYCLES   = 3'h4;
    localparam int          OSC_RATE_HZ     = 128000;
    localparam int          BASE_OSC_CYCLES = 2048;
    localparam int          COUNT_W         = 21;

endpackage

// [verilog/sptm_osc_sync.sv]
// oscillator pin synchroniser: turns the free running 128 kHz input
// into a one-cycle tick per rising edge in the system clock domain
// assumes the oscillator is far slower than CLK
`timescale 1ns/1ps
module sptm_osc_sync (
    input  wire logic CLK,
    input  wire logic RESET,
    input  wire logic OSC_IN,
    output logic      TICK
);
    import sptm_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic tick;
    } sptm_sync_t;

    sptm_sync_t s_q;
    sptm_sync_t s_d;

    // ------------------------------------------------------------
    // three stage capture, level accepted once stages 2 and 3 agree
    // ------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.s1    = OSC_IN;
        s_d.s2    = s_q.s1;
        s_d.s3    = s_q.s2;
        s_d.tick  = 1'b0;
        if (s_q.s2 == s_q.s3) begin
            s_d.level = s_q.s3;                                  // R25
            s_d.tick  = s_q.s3 & ~s_q.level;                     // R1
        end
        if (RESET) begin
            s_d = '0;
        end
    end

    always_ff @(posedge CLK) begin
        s_q <= s_d;
    end

    assign TICK = s_q.tick;

endmodule

// [verilog/sptm_supervision_timer.sv]
// supervision timer with reset cause flags, registers on APB
// assumes: OSC_128K is a free running pin from the on-chip oscillator,
// reset event inputs are one-cycle pulses on CLK, ALWAYS_ON_FUSE is static
//
// Behaviour
// R1 - counter advances on ticks of the separate 128 kHz oscillator
// R2 - time-out gives interrupt, reset or both by active mode
// R3 - restart command clears the counter to zero
// R4 - interrupt mode: expiry sets irq flag only, usable as wake-up
// R5 - reset mode: expiry requests a system reset
// R6 - combined mode: first expiry interrupts, vector then leaves interrupt mode for reset mode
// R7 - always-on fuse forces reset enable to one, irq enable to zero
// R8 - software opens a change by writing unlock and reset enable together
// R9 - reset enable clear or period change only in the four cycle window
// R10 - time-out selectable from 16 ms up to 8 s
// R11 - software should restart before shortening the period
// R12 - timeout cause set by watchdog reset, cleared by power-up or zero write
// R13 - supply drop cause set by brown-out, cleared by power-up or zero write
// R14 - pin cause set by external reset, cleared by power-up or zero write
// R15 - power-up cause set by power-on, cleared only by zero write
// R16 - cause register bits 7 to 4 read zero
// R17 - control register layout at 0x60, fields reset to zero
// R18 - after a watchdog reset the timer stays enabled
// R19 - init code should clear timeout cause and reset enable
// R20 - software should read then clear cause register early
// R21 - reset enable reads one and cannot clear while timeout cause set
// R22 - unlock bit clears itself four cycles after being written
// R23 - period code n selects 2048 shl n oscillator cycles, 10-15 reserved
// R24 - expiry sets irq flag; vector or writing one clears it
// R25 - oscillator edges cross safely into the system clock domain
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module sptm_supervision_timer #(
    parameter int BASE_CYCLES = sptm_pkg::BASE_OSC_CYCLES
) (
    input  wire logic                            CLK,
    input  wire logic                            RESET,
    input  wire logic                            POWERUP_RST,
    input  wire logic                            PIN_RST_EVENT,
    input  wire logic                            SUPPLY_DROP_EVENT,
    input  wire logic                            ALWAYS_ON_FUSE,
    input  wire logic                            OSC_128K,
    input  wire logic                            RESTART,
    input  wire logic                            IRQ_ACK,
    input  wire logic                            PSEL,
    input  wire logic                            PENABLE,
    input  wire logic                            PWRITE,
    input  wire logic [sptm_pkg::APB_ADDR_W-1:0] PADDR,
    input  wire logic [sptm_pkg::APB_DATA_W-1:0] PWDATA,
    output logic      [sptm_pkg::APB_DATA_W-1:0] PRDATA,
    output logic                                 PREADY,
    output logic                                 PSLVERR,
    output logic                                 TIMEOUT_IRQ,
    output logic                                 SYS_RESET_REQ
);
    import sptm_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic               irq_flag;
        logic               irq_en;
        logic               rst_en;
        logic [3:0]         period;
        logic [2:0]         unlock_cnt;
        logic [COUNT_W-1:0] count;
        logic               cause_timeout;
        logic               cause_supply;
        logic               cause_pin;
        logic               cause_power;
        logic               pready;
        logic               pslverr;
        logic [REG_W-1:0]   prdata;
        logic               sys_rst;
        logic               irq_out;
    } sptm_state_t;

    sptm_state_t s_q;
    sptm_state_t s_d;

    logic osc_tick;

    // ------------------------------------------------------------
    // oscillator edge capture
    // ------------------------------------------------------------
    sptm_osc_sync u_osc_sync (
        .CLK    (CLK),
        .RESET  (RESET),
        .OSC_IN (OSC_128K),
        .TICK   (osc_tick)
    );

    // ------------------------------------------------------------
    // derived control
    // ------------------------------------------------------------
    logic               eff_rst_en;
    logic               eff_irq_en;
    logic               running;
    logic               unlock_open;
    logic [3:0]         period_use;
    logic [COUNT_W-1:0] limit;
    logic [COUNT_W-1:0] count_inc;
    logic [REG_W-1:0]   ctrl_rd;
    logic [REG_W-1:0]   cause_rd;
    logic               hit_ctrl;
    logic               hit_cause;
    logic               apb_acc;
    logic               apb_commit;
    logic [REG_W-1:0]   wd;

    // effective mode bits; fuse overrides both stored bits, timeout cause only the reset enable
    always_comb begin
        eff_rst_en  = s_q.rst_en | s_q.cause_timeout | ALWAYS_ON_FUSE;   // R7 R21
        eff_irq_en  = s_q.irq_en & ~ALWAYS_ON_FUSE;                       // R7
        running     = eff_rst_en | eff_irq_en;
        unlock_open = (s_q.unlock_cnt != 3'h0);
        // reserved codes behave as the longest period rather than wrapping
        period_use  = (s_q.period > PERIOD_MAX) ? PERIOD_MAX : s_q.period; // R23
        limit       = COUNT_W'(BASE_CYCLES) << period_use;                  // R23 R10
        count_inc   = s_q.count + COUNT_W'(1);
    end

    // register read images
    always_comb begin
        ctrl_rd                        = '0;
        ctrl_rd[IRQ_FLAG_BIT]          = s_q.irq_flag;                   // R17
        ctrl_rd[IRQ_EN_BIT]            = eff_irq_en;
        ctrl_rd[PER3_BIT]              = s_q.period[3];
        ctrl_rd[UNLOCK_BIT]            = unlock_open;
        ctrl_rd[RST_EN_BIT]            = eff_rst_en;                     // R21
        ctrl_rd[PER_LO_MSB:PER_LO_LSB] = s_q.period[2:0];
        cause_rd                       = {CAUSE_UNUSED_RD,               // R16
                                          s_q.cause_timeout,
                                          s_q.cause_supply,
                                          s_q.cause_pin,
                                          s_q.cause_power};
    end

    // bus decode; a write lands only at the edge where pready is seen high
    always_comb begin
        hit_ctrl   = (PADDR == CTRL_ADDR);
        hit_cause  = (PADDR == CAUSE_ADDR);
        apb_acc    = PSEL & PENABLE;
        apb_commit = apb_acc & s_q.pready & PWRITE;
        wd         = PWDATA[REG_W-1:0];
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d         = s_q;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.sys_rst = 1'b0;

        // apb access phase: one wait state, then data and ready from flops
        if (apb_acc & ~s_q.pready) begin
            s_d.pready  = 1'b1;
            s_d.pslverr = ~(hit_ctrl | hit_cause);
            s_d.prdata  = hit_ctrl ? ctrl_rd : (hit_cause ? cause_rd : '0);
        end

        // unlock window counts down by itself
        if (unlock_open) begin
            s_d.unlock_cnt = s_q.unlock_cnt - 3'h1;                      // R22
        end

        // control register write
        if (apb_commit & hit_ctrl) begin
            if (wd[IRQ_FLAG_BIT]) begin
                s_d.irq_flag = 1'b0;                                     // R24
            end
            s_d.irq_en = wd[IRQ_EN_BIT];
            if (wd[UNLOCK_BIT] & wd[RST_EN_BIT]) begin
                // unlock request; also sets reset enable as written
                s_d.unlock_cnt = UNLOCK_CYCLES;                          // R8 R22
                s_d.rst_en     = 1'b1;
            end else if (unlock_open & ~wd[UNLOCK_BIT]) begin
                // the one write inside the window may clear and re-period
                s_d.rst_en = wd[RST_EN_BIT];                             // R9
                s_d.period = {wd[PER3_BIT], wd[PER_LO_MSB:PER_LO_LSB]}; // R9
            end else if (wd[RST_EN_BIT]) begin
                s_d.rst_en = 1'b1;                                       // R9
            end
        end

        // cause register write: a zero clears, a one leaves the flag alone
        if (apb_commit & hit_cause) begin
            s_d.cause_timeout = s_q.cause_timeout & wd[CAUSE_TIMEOUT_BIT]; // R12
            s_d.cause_supply  = s_q.cause_supply & wd[CAUSE_SUPPLY_BIT];   // R13
            s_d.cause_pin     = s_q.cause_pin & wd[CAUSE_PIN_BIT];         // R14
            s_d.cause_power   = s_q.cause_power & wd[CAUSE_POWER_BIT];     // R15
        end

        // interrupt vector taken; in combined mode drop back to reset mode
        if (IRQ_ACK) begin
            s_d.irq_flag = 1'b0;                                         // R24
            if (eff_rst_en) begin
                s_d.irq_en = 1'b0;                                       // R6
            end
        end

        // counter; a shortened period expires at once on the next tick
        if (RESTART | ~running) begin
            s_d.count = '0;                                              // R3
        end else if (osc_tick) begin
            if (count_inc >= limit) begin
                s_d.count = '0;
                if (eff_irq_en & ~eff_rst_en) begin
                    s_d.irq_flag = 1'b1;                                 // R4 R2
                end else if (eff_irq_en & eff_rst_en & ~s_q.irq_flag) begin
                    s_d.irq_flag = 1'b1;                                 // R6
                end else begin
                    s_d.sys_rst       = 1'b1;                            // R5 R2
                    s_d.cause_timeout = 1'b1;                            // R12
                end
            end else begin
                s_d.count = count_inc;                                   // R1
            end
        end

        // reset source events; placed after the cause write so a set beats a zero write
        if (PIN_RST_EVENT) begin
            s_d.cause_pin = 1'b1;                                        // R14
        end
        if (SUPPLY_DROP_EVENT) begin
            s_d.cause_supply = 1'b1;                                     // R13
        end

        // system reset returns control to defaults, cause flags survive
        if (RESET) begin
            s_d.irq_flag   = 1'b0;                                       // R17
            s_d.irq_en     = 1'b0;
            s_d.rst_en     = 1'b0;
            s_d.period     = PERIOD_RST;
            s_d.unlock_cnt = '0;
            s_d.count      = '0;
            s_d.pready     = 1'b0;
            s_d.pslverr    = 1'b0;
            s_d.prdata     = '0;
            s_d.sys_rst    = 1'b0;
        end

        // power-up clears everything and records itself
        if (POWERUP_RST) begin
            s_d             = '0;
            s_d.period      = PERIOD_RST;
            s_d.cause_power = 1'b1;                                      // R15
        end

        // a latched timeout cause keeps reset mode alive through reset
        if (s_d.cause_timeout | ALWAYS_ON_FUSE) begin
            s_d.rst_en = 1'b1;                                           // R18 R21 R7
        end
        if (ALWAYS_ON_FUSE) begin
            s_d.irq_en = 1'b0;                                           // R7
        end

        // interrupt line follows flag gated by enable
        s_d.irq_out = s_d.irq_flag & s_d.irq_en;                         // R4 R24
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign PRDATA        = {{(APB_DATA_W-REG_W){1'b0}}, s_q.prdata};
    assign PREADY        = s_q.pready;
    assign PSLVERR       = s_q.pslverr;
    assign TIMEOUT_IRQ   = s_q.irq_out;
    assign SYS_RESET_REQ = s_q.sys_rst;

endmodule

// [test/sptm_supervision_timer_props.sv]
// checker for the supervision timer port behaviour
// assumes it is bound into the top module and sees only its ports
`timescale 1ns/1ps
module sptm_props
    import sptm_pkg::*;
(
    input wire logic                            CLK,
    input wire logic                            RESET,
    input wire logic                            POWERUP_RST,
    input wire logic                            ALWAYS_ON_FUSE,
    input wire logic                            PSEL,
    input wire logic                            PENABLE,
    input wire logic                            PWRITE,
    input wire logic [sptm_pkg::APB_ADDR_W-1:0] PADDR,
    input wire logic [sptm_pkg::APB_DATA_W-1:0] PRDATA,
    input wire logic                            PREADY,
    input wire logic                            PSLVERR,
    input wire logic                            TIMEOUT_IRQ,
    input wire logic                            SYS_RESET_REQ
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET || POWERUP_RST);
    // --------------------------------------------------------
    // bus timing
    // --------------------------------------------------------
    sequence s_open;
        PSEL && PENABLE && !$past(PENABLE);
    endsequence
    sequence s_one_wait;
        !PREADY ##1 PREADY;
    endsequence
    chk_ready_one_wait: assert property (s_open |-> s_one_wait)
        else $error("ready not after one wait state");
    chk_ready_in_access: assert property (PREADY |-> (PSEL && PENABLE) ##1 !PREADY)
        else $error("ready outside a single access cycle");
    chk_err_unmapped: assert property (PREADY |-> PSLVERR == !(PADDR == CTRL_ADDR || PADDR == CAUSE_ADDR))
        else $error("error response does not match address");
    chk_err_read_zero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == '0)
        else $error("refused read returned data");
    chk_upper_bits_zero: assert property (PREADY && !PWRITE |->
        PRDATA[31:8] == '0 && (PADDR != CAUSE_ADDR || PRDATA[7:4] == 4'h0))
        else $error("unused read bits not zero");
    // --------------------------------------------------------
    // resets, pulses and the fuse
    // --------------------------------------------------------
    // a system reset must silence ready, irq, reset request and read data one edge later
    chk_reset_quiet: assert property (disable iff (POWERUP_RST)
        RESET |=> !PREADY && !TIMEOUT_IRQ && !SYS_RESET_REQ && PRDATA == '0)
        else $error("outputs active during reset");
    chk_reset_pulse: assert property (SYS_RESET_REQ |=> !SYS_RESET_REQ)
        else $error("reset request longer than one cycle");
    chk_fuse_no_irq: assert property (ALWAYS_ON_FUSE && $past(ALWAYS_ON_FUSE) |-> !TIMEOUT_IRQ)
        else $error("interrupt raised with fuse programmed");
    chk_fuse_ctrl_read: assert property (PREADY && !PWRITE && PADDR == CTRL_ADDR && ALWAYS_ON_FUSE &&
        $past(ALWAYS_ON_FUSE, 3) |-> PRDATA[RST_EN_BIT] && !PRDATA[IRQ_EN_BIT])
        else $error("fuse does not force reset mode bits");
endmodule
bind sptm_supervision_timer sptm_props u_sptm_props (.CLK(CLK), .RESET(RESET), .POWERUP_RST(POWERUP_RST),
    .ALWAYS_ON_FUSE(ALWAYS_ON_FUSE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMEOUT_IRQ(TIMEOUT_IRQ), .SYS_RESET_REQ(SYS_RESET_REQ));

// [test/sptm_supervision_timer_bench.sv]
// self-checking bench for the supervision timer with reset cause flags
// assumes design files and checker are compiled ahead of it
`timescale 1ns/1ps
module sptm_supervision_timer_bench;
    import sptm_pkg::*;
    // --------------------------------------------------------
    // stimulus, clocks and counters
    // --------------------------------------------------------
    localparam int OSC_HALF = 98; // 196 clocks per period is close to 128 kHz
    localparam int BASE     = 8;  // short base count keeps the run small
    logic        CLK = 1'b0, RESET = 1'b1, POWERUP_RST = 1'b1, OSC_128K = 1'b0;
    logic        PIN_RST_EVENT = 1'b0, SUPPLY_DROP_EVENT = 1'b0, ALWAYS_ON_FUSE = 1'b0;
    logic        RESTART = 1'b0, IRQ_ACK = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0;
    wire  [31:0] PRDATA;
    wire         PREADY, PSLVERR, TIMEOUT_IRQ, SYS_RESET_REQ;
    logic [7:0]  rd_q;
    logic        rd_e;
    int          mismatches = 0, n_compared = 0, osc_cnt = 0;

    sptm_supervision_timer #(.BASE_CYCLES(BASE)) u_sptm_supervision_timer (.CLK(CLK), .RESET(RESET),
        .POWERUP_RST(POWERUP_RST), .PIN_RST_EVENT(PIN_RST_EVENT), .SUPPLY_DROP_EVENT(SUPPLY_DROP_EVENT),
        .ALWAYS_ON_FUSE(ALWAYS_ON_FUSE), .OSC_128K(OSC_128K), .RESTART(RESTART), .IRQ_ACK(IRQ_ACK),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMEOUT_IRQ(TIMEOUT_IRQ), .SYS_RESET_REQ(SYS_RESET_REQ));

    always #(CLK_PERIOD_NS / 2) CLK = ~CLK;
    // free running oscillator, unrelated to any bus activity
    always @(posedge CLK) begin
        osc_cnt <= (osc_cnt == OSC_HALF - 1) ? 0 : osc_cnt + 1;
        if (osc_cnt == OSC_HALF - 1) OSC_128K <= ~OSC_128K;
    end
    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ch starts from a select still held; hold keeps psel so the next transfer follows at once
    task automatic apb(input bit ch, input bit hold, input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        if (!ch) @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= {24'h000000, d};
        @(posedge CLK);
        PENABLE <= 1'b1;
        n = 0;
        // request held until the rising edge at which ready is sampled high
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        if (n >= 16) mismatches++;
        rd_q = PRDATA[7:0];
        rd_e = PSLVERR;
        PENABLE <= 1'b0;
        if (!hold) PSEL <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, 1'b0, 1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, 1'b0, 1'b0, a, 8'h00);
        check(32'({rd_e, rd_q}), 32'({1'b0, exp}));
    endtask
    // timed pair: the second write lands three cycles after the first
    task automatic unlock(input logic [7:0] d);
        apb(1'b0, 1'b1, 1'b1, CTRL_ADDR, 8'h18);
        apb(1'b1, 1'b0, 1'b1, CTRL_ADDR, d);
    endtask
    task automatic pulse(input int k);
        @(posedge CLK);
        case (k)
            0: RESTART <= 1'b1;
            1: IRQ_ACK <= 1'b1;
            2: PIN_RST_EVENT <= 1'b1;
            default: SUPPLY_DROP_EVENT <= 1'b1;
        endcase
        @(posedge CLK);
        {RESTART, IRQ_ACK, PIN_RST_EVENT, SUPPLY_DROP_EVENT} <= 4'h0;
    endtask
    task automatic sys_reset(input bit por);
        @(posedge CLK);
        RESET <= 1'b1;
        POWERUP_RST <= por;
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        POWERUP_RST <= 1'b0;
    endtask
    // restart, then time the irq (sel 0) or reset request (sel 1) against the period code
    task automatic expire(input bit sel, input int p);
        int n, lo, hi;
        bit other;
        lo = ((BASE << p) - 1) * 2 * OSC_HALF - 8;
        hi = (BASE << p) * 2 * OSC_HALF + 12;
        pulse(0);
        n = 0;
        other = 1'b0;
        do begin
            @(negedge CLK);
            n++;
            if (SYS_RESET_REQ === 1'b1 && !sel) other = 1'b1;
        end while ((sel ? SYS_RESET_REQ : TIMEOUT_IRQ) !== 1'b1 && n < hi);
        check(32'(n >= lo && n < hi), 32'h1);
        check(32'(other), 32'h0);
    endtask
    // --------------------------------------------------------
    // test sequence
    // --------------------------------------------------------
    initial begin
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        POWERUP_RST <= 1'b0;
        rd(CTRL_ADDR, 8'h00);
        rd(CAUSE_ADDR, 8'h01);
        apb(1'b0, 1'b0, 1'b0, 12'h068, 8'h00);
        check(32'({rd_e, rd_q}), 32'h100);
        wr(CTRL_ADDR, 8'h40);
        repeat (4) begin
            pulse(0);
            repeat (1000) @(posedge CLK);
        end
        check(32'(TIMEOUT_IRQ), 32'h0);
        expire(1'b0, 0);
        rd(CTRL_ADDR, 8'hc0);
        wr(CTRL_ADDR, 8'hc0);
        rd(CTRL_ADDR, 8'h40);
        pulse(0);
        unlock(8'h41);
        expire(1'b0, 1);
        pulse(1);
        rd(CTRL_ADDR, 8'h41);
        unlock(8'h00);
        pulse(0);
        wr(CTRL_ADDR, 8'h0a);
        rd(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h18);
        repeat (8) @(posedge CLK);
        wr(CTRL_ADDR, 8'h00);
        rd(CTRL_ADDR, 8'h08);
        unlock(8'h00);
        rd(CTRL_ADDR, 8'h00);
        unlock(8'h08);
        expire(1'b1, 0);
        rd(CAUSE_ADDR, 8'h09);
        sys_reset(1'b0);
        pulse(0);
        rd(CTRL_ADDR, 8'h08);
        unlock(8'h00);
        rd(CTRL_ADDR, 8'h08);
        wr(CAUSE_ADDR, 8'h01);
        rd(CAUSE_ADDR, 8'h01);
        unlock(8'h00);
        rd(CTRL_ADDR, 8'h00);
        unlock(8'h48);
        expire(1'b0, 0);
        pulse(1);
        rd(CTRL_ADDR, 8'h08);
        expire(1'b1, 0);
        sys_reset(1'b0);
        pulse(2);
        pulse(3);
        rd(CAUSE_ADDR, 8'h0f);
        wr(CAUSE_ADDR, 8'h08);
        rd(CAUSE_ADDR, 8'h08);
        pulse(2);
        sys_reset(1'b0);
        rd(CAUSE_ADDR, 8'h0a);
        sys_reset(1'b1);
        rd(CAUSE_ADDR, 8'h01);
        @(posedge CLK);
        ALWAYS_ON_FUSE <= 1'b1;
        wr(CTRL_ADDR, 8'h40);
        rd(CTRL_ADDR, 8'h08);
        end_sim();
    end
    // hang guard, well beyond the expected run length
    initial begin
        #(CLK_PERIOD_NS * 60000);
        mismatches++;
        end_sim();
    end
endmodule
